// [igoc_top.sv]
// Purpose: Gain, range and offset trim registers for two measurement channels
// Assumes: Host frames are command byte then data byte, both MSB first
// Notes:   Register values cross from the serial clock by toggle and snapshot
//
// Functional notes
// RULE1: The master clock must be supplied at its working rate by the outside.
// RULE2: All serial transfers are timed by the host-driven serial clock.
// RULE3: Serial activity is ignored while the active-low select is high.
// RULE4: Outgoing data bits change on the rising serial clock edge.
// RULE5: Incoming data bits are captured on the falling serial clock edge.
// RULE6: The data output is released except while returning read data.
// RULE7: Each channel gain can be chosen as 1, 2, 4, 8 or 16.
// RULE8: Gain register bits 2 to 0 set the channel 1 gain.
// RULE9: Gain register bits 7 to 5 set the channel 2 gain.
// RULE10: Gain register bits 4 and 3 pick the channel 1 input range.
// RULE11: Each channel has its own writable offset trim register.
// RULE12: Offset trims are sign and five-bit magnitude numbers.
// RULE13: The host never writes a trim magnitude above 31.
// RULE14: Channel 1 trim top bit enables the integrator, on after reset.
// RULE15: Gain codes 0 to 4 mean x1 to x16; range codes 0 to 2 mean 0.5, 0.25, 0.125 V.
// RULE16: Registers hold their written values and read back over the port.
`timescale 1ns/100ps
module igoc_top (
	input wire logic  clk_sys,
	input wire logic  srst,
	input wire logic  cs_n,
	input wire logic  sclk,
	input wire logic  din,
	output logic      dout,
	output logic      dout_oe,
	output logic [2:0] ch1_gain_shift,
	output logic [2:0] ch2_gain_shift,
	output logic [1:0] ch1_range_sel,
	output logic [5:0] ch1_offset,
	output logic [5:0] ch2_offset,
	output logic      ch1_integrator_en
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	igoc_link_if link_if ();

	logic       cs_meta;
	logic       cs_sync;
	logic       tg_meta;
	logic       tg_sync;
	logic       tg_last;
	logic       wr_evt;
	logic [7:0] gain_sel;
	logic [7:0] ch1_trim;
	logic [5:0] ch2_trim;
	logic       addr_hit;

	// ----------------------------------------------------------------
	// Serial clock end
	// ----------------------------------------------------------------
	igoc_serial_link u_link (
		.sclk     (sclk),
		.cs_n     (cs_n),
		.din      (din),
		.link_rst (srst),
		.lk       (link_if.link)
	);

	// Pin outputs come straight from link flops
	assign dout    = link_if.dout;
	assign dout_oe = link_if.dout_oe;

	// ----------------------------------------------------------------
	// Crossings into the system clock
	// ----------------------------------------------------------------

	// Select level through two flops; only the second is looked at
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			cs_meta <= 1'b1;
			cs_sync <= 1'b1;
		end
		else
		begin
			cs_meta <= cs_n;
			cs_sync <= cs_meta;                           // [RULE3]
		end
	end

	// Write toggle through two flops, then an edge compare
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			tg_meta <= 1'b0;
			tg_sync <= 1'b0;
			tg_last <= 1'b0;
		end
		else
		begin
			tg_meta <= link_if.wr_tgl;
			tg_sync <= tg_meta;
			tg_last <= tg_sync;
		end
	end

	// Write fields are stable long before the toggle edge is seen
	assign wr_evt   = tg_sync ^ tg_last;                  // [RULE1]
	assign addr_hit = (link_if.wr_addr == igoc_pkg::ADDR_GAIN_SEL)
		|| (link_if.wr_addr == igoc_pkg::ADDR_CH1_TRIM)
		|| (link_if.wr_addr == igoc_pkg::ADDR_CH2_TRIM);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------

	// Gain and range selection
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			gain_sel <= igoc_pkg::GAIN_SEL_RST;
		else if (wr_evt && link_if.wr_addr == igoc_pkg::ADDR_GAIN_SEL)
			gain_sel <= link_if.wr_data;                  // [RULE16]
	end

	// Channel 1 trim; bit 6 is reserved and kept at zero
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			ch1_trim <= igoc_pkg::CH1_TRIM_RST;           // [RULE14]
		else if (wr_evt && link_if.wr_addr == igoc_pkg::ADDR_CH1_TRIM)
			ch1_trim <= {link_if.wr_data[7], 1'b0, link_if.wr_data[5:0]}; // [RULE11]
	end

	// Channel 2 trim; upper bits are not stored
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			ch2_trim <= igoc_pkg::CH2_TRIM_RST;
		else if (wr_evt && link_if.wr_addr == igoc_pkg::ADDR_CH2_TRIM)
			ch2_trim <= link_if.wr_data[5:0];             // [RULE11]
	end

	// ----------------------------------------------------------------
	// Read snapshot
	// ----------------------------------------------------------------

	// Refreshed only while deselected, so a frame reads a frozen word.
	// Trade: a write becomes readable only after the select goes high.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			link_if.snap_gain <= igoc_pkg::GAIN_SEL_RST;
			link_if.snap_ch1  <= igoc_pkg::CH1_TRIM_RST;
			link_if.snap_ch2  <= {2'b00, igoc_pkg::CH2_TRIM_RST};
		end
		else if (cs_sync)
		begin
			link_if.snap_gain <= gain_sel;                // [RULE16]
			link_if.snap_ch1  <= ch1_trim;
			link_if.snap_ch2  <= {2'b00, ch2_trim};
		end
	end

	// ----------------------------------------------------------------
	// Decoded controls for the analog front end
	// ----------------------------------------------------------------

	// Gain shifts; codes above four saturate at x16
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ch1_gain_shift <= 3'h0;
			ch2_gain_shift <= 3'h0;
		end
		else
		begin
			ch1_gain_shift <= igoc_pkg::gain_shift(
				gain_sel[igoc_pkg::GAIN_CH1_LSB +: 3]);   // [RULE7] [RULE8] [RULE15]
			ch2_gain_shift <= igoc_pkg::gain_shift(
				gain_sel[igoc_pkg::GAIN_CH2_LSB +: 3]);   // [RULE7] [RULE9] [RULE15]
		end
	end

	// Range code passed as written; code 3 is left to the front end
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			ch1_range_sel <= 2'h0;
		else
			ch1_range_sel <= gain_sel[igoc_pkg::GAIN_RANGE_LSB +: 2]; // [RULE10] [RULE15]
	end

	// Offsets in two's complement for the correction adders
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ch1_offset <= 6'h00;
			ch2_offset <= 6'h00;
		end
		else
		begin
			ch1_offset <= igoc_pkg::sm_to_twos(ch1_trim[5:0]); // [RULE12]
			ch2_offset <= igoc_pkg::sm_to_twos(ch2_trim);      // [RULE12]
		end
	end

	// Integrator enable; comes up on so coil sensors work from reset
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			ch1_integrator_en <= 1'b1;                    // [RULE14]
		else
			ch1_integrator_en <= ch1_trim[igoc_pkg::INTEG_EN_BIT]; // [RULE14]
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	a_gain_write_lands: assert property ( // [RULE16]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_GAIN_SEL
		|=> gain_sel == $past(link_if.wr_data))
		else $error("gain register missed a write");

	a_ch1_gain_field: assert property ( // [RULE8]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_GAIN_SEL
		|-> ##2 ch1_gain_shift == igoc_pkg::gain_shift($past(link_if.wr_data[2:0], 2)))
		else $error("channel 1 gain does not follow bits 2..0");

	a_ch2_gain_field: assert property ( // [RULE9]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_GAIN_SEL
		|-> ##2 ch2_gain_shift == igoc_pkg::gain_shift($past(link_if.wr_data[7:5], 2)))
		else $error("channel 2 gain does not follow bits 7..5");

	a_range_field: assert property ( // [RULE10]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_GAIN_SEL
		|-> ##2 ch1_range_sel == $past(link_if.wr_data[4:3], 2))
		else $error("range select does not follow bits 4..3");

	a_ch1_offset_sm: assert property ( // [RULE12]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_CH1_TRIM
		|-> ##2 ch1_offset == igoc_pkg::sm_to_twos($past(link_if.wr_data[5:0], 2)))
		else $error("channel 1 offset decode wrong");

	a_ch2_offset_sm: assert property ( // [RULE12]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_CH2_TRIM
		|-> ##2 ch2_offset == igoc_pkg::sm_to_twos($past(link_if.wr_data[5:0], 2)))
		else $error("channel 2 offset decode wrong");

	a_integ_after_reset: assert property ( // [RULE14]
		$past(srst) |-> ch1_integrator_en && ch1_trim[igoc_pkg::INTEG_EN_BIT])
		else $error("integrator not enabled after reset");

	a_snap_frozen: assert property ( // [RULE3]
		!cs_sync && $past(!cs_sync)
		|-> $stable(link_if.snap_gain) && $stable(link_if.snap_ch1)
		&& $stable(link_if.snap_ch2))
		else $error("snapshot changed during a frame");

	a_unmapped_ignored: assert property ( // [RULE16]
		wr_evt && !addr_hit
		|=> $stable(gain_sel) && $stable(ch1_trim) && $stable(ch2_trim))
		else $error("write to unmapped address changed a register");

	a_snap_catches_up: assert property ( // [RULE16]
		cs_sync ##1 cs_sync |-> link_if.snap_gain == $past(gain_sel))
		else $error("snapshot did not follow the gain register");

	// ----------------------------------------------------------------
	// Hold, crossing and decode checks
	// ----------------------------------------------------------------

	// Decoded gains never leave the x1 to x16 set
	a_gain_shift_limit: assert property ( // [RULE7]
		ch1_gain_shift <= igoc_pkg::GAIN_CODE_MAX
		&& ch2_gain_shift <= igoc_pkg::GAIN_CODE_MAX)
		else $error("gain shift outside the x1 to x16 set");

	a_ch1_gain_sat: assert property ( // [RULE15]
		gain_sel[igoc_pkg::GAIN_CH1_LSB +: 3] > igoc_pkg::GAIN_CODE_MAX
		|=> ch1_gain_shift == igoc_pkg::GAIN_CODE_MAX)
		else $error("channel 1 undefined gain code not saturated");

	a_ch2_gain_sat: assert property ( // [RULE15]
		gain_sel[igoc_pkg::GAIN_CH2_LSB +: 3] > igoc_pkg::GAIN_CODE_MAX
		|=> ch2_gain_shift == igoc_pkg::GAIN_CODE_MAX)
		else $error("channel 2 undefined gain code not saturated");

	// Trim registers take the written byte, reserved bits forced low
	a_ch1_trim_write: assert property ( // [RULE11]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_CH1_TRIM
		|=> ch1_trim == {$past(link_if.wr_data[7]), 1'b0, $past(link_if.wr_data[5:0])})
		else $error("channel 1 trim missed a write");

	a_ch2_trim_write: assert property ( // [RULE11]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_CH2_TRIM
		|=> ch2_trim == $past(link_if.wr_data[5:0]))
		else $error("channel 2 trim missed a write");

	a_integ_follows_bit: assert property ( // [RULE14]
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_CH1_TRIM
		|-> ##2 ch1_integrator_en == $past(link_if.wr_data[7], 2))
		else $error("integrator enable does not follow the trim top bit");

	// Without a write event no register may move
	a_regs_hold: assert property ( // [RULE16]
		!wr_evt |=> $stable(gain_sel) && $stable(ch1_trim) && $stable(ch2_trim))
		else $error("register changed without a write");

	// Fields must already be settled when the toggle edge is seen
	a_wr_fields_steady: assert property ( // [RULE16]
		wr_evt |-> $stable(link_if.wr_addr) && $stable(link_if.wr_data))
		else $error("write fields moved while being taken");

	a_range_tracks: assert property ( // [RULE10]
		ch1_range_sel == $past(gain_sel[igoc_pkg::GAIN_RANGE_LSB +: 2]))
		else $error("range select does not track the gain register");

	a_ch1_offset_tracks: assert property ( // [RULE12]
		ch1_offset == igoc_pkg::sm_to_twos($past(ch1_trim[5:0])))
		else $error("channel 1 offset does not track its trim");

	a_ch2_offset_tracks: assert property ( // [RULE12]
		ch2_offset == igoc_pkg::sm_to_twos($past(ch2_trim)))
		else $error("channel 2 offset does not track its trim");

	// Pin stays released once the select has settled high
	a_oe_idle_quiet: assert property ( // [RULE6]
		cs_sync && $past(cs_sync) |-> !dout_oe)
		else $error("data output enabled while deselected");

	a_snap_reserved: assert property ( // [RULE16]
		!link_if.snap_ch1[6] && link_if.snap_ch2[7:6] == 2'b00)
		else $error("reserved trim bits read back as one");

	c_gain_write: cover property (
		wr_evt && link_if.wr_addr == igoc_pkg::ADDR_GAIN_SEL);
	c_integ_off: cover property ($fell(ch1_integrator_en));
	c_neg_offset: cover property (ch2_offset[5] && !$past(ch2_offset[5]));
	// A full frame keeps the select low for about two hundred cycles
	c_read_frame: cover property ($fell(cs_sync) ##[1:300] $rose(cs_sync));
	c_range_top: cover property (ch1_range_sel == 2'h2);

endmodule : igoc_top

// [igoc_pkg.sv]
// Purpose: Shared constants and helpers for the gain and offset configuration block
// Assumes: Registers sit at six-bit addresses carried in a two-byte serial frame
// Notes:   Field positions, reset values and frame counts live here only once
package igoc_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_GAIN_SEL = 6'h01;
	localparam logic [5:0] ADDR_CH1_TRIM = 6'h02;
	localparam logic [5:0] ADDR_CH2_TRIM = 6'h03;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         GAIN_CH1_LSB   = 0;
	localparam int         GAIN_RANGE_LSB = 3;
	localparam int         GAIN_CH2_LSB   = 5;
	localparam int         TRIM_SIGN_BIT  = 5;
	localparam int         INTEG_EN_BIT   = 7;
	localparam int         CMD_WRITE_BIT  = 7;
	localparam logic [7:0] GAIN_SEL_RST   = 8'h00;
	localparam logic [7:0] CH1_TRIM_RST   = 8'h80;
	localparam logic [5:0] CH2_TRIM_RST   = 6'h00;
	localparam logic [2:0] GAIN_CODE_MAX  = 3'h4;

	// ----------------------------------------------------------------
	// Serial frame bit counts
	// ----------------------------------------------------------------
	localparam logic [4:0] CMD_LAST   = 5'h07;
	localparam logic [4:0] CMD_BITS   = 5'h08;
	localparam logic [4:0] DATA_LAST  = 5'h0f;
	localparam logic [4:0] FRAME_BITS = 5'h10;

	// Gain code to left shift; undefined codes saturate at x16
	function automatic logic [2:0] gain_shift(input logic [2:0] code);
		gain_shift = (code > GAIN_CODE_MAX) ? GAIN_CODE_MAX : code;
	endfunction : gain_shift

	// Sign and magnitude to two's complement; minus zero becomes zero
	function automatic logic [5:0] sm_to_twos(input logic [5:0] sm);
		logic [5:0] mag;
		mag = {1'b0, sm[4:0]};
		sm_to_twos = sm[TRIM_SIGN_BIT] ? 6'(-mag) : mag;
	endfunction : sm_to_twos

endpackage : igoc_pkg

// [igoc_link_if.sv]
// Purpose: Carrier between the serial link logic and the system-clock core
// Assumes: Write fields hold still from one toggle to the next
// Notes:   Snapshot words are frozen by the core while the select is low
`timescale 1ns/100ps
interface igoc_link_if;
	logic       wr_tgl;
	logic [5:0] wr_addr;
	logic [7:0] wr_data;
	logic [7:0] snap_gain;
	logic [7:0] snap_ch1;
	logic [7:0] snap_ch2;
	logic       dout;
	logic       dout_oe;

	// Link side runs on the serial clock
	modport link (
		output wr_tgl,
		output wr_addr,
		output wr_data,
		output dout,
		output dout_oe,
		input  snap_gain,
		input  snap_ch1,
		input  snap_ch2
	);

	// Core side runs on the system clock
	modport core (
		input  wr_tgl,
		input  wr_addr,
		input  wr_data,
		input  dout,
		input  dout_oe,
		output snap_gain,
		output snap_ch1,
		output snap_ch2
	);
endinterface : igoc_link_if

// [igoc_serial_link.sv]
// Purpose: Serial clock domain end of the four-wire register port
// Assumes: Serial clock idles high and runs only while the select is low
// Notes:   Select high clears the frame state without needing a clock edge
`timescale 1ns/100ps
module igoc_serial_link (
	input wire logic  sclk,
	input wire logic  cs_n,
	input wire logic  din,
	input wire logic  link_rst,
	igoc_link_if.link lk
);
	logic [4:0] bit_cnt;
	logic [6:0] shift;
	logic [7:0] cmd;
	logic [7:0] rd_byte;

	// Bit counter and input shifter, captured on the falling edge
	always_ff @(negedge sclk or posedge cs_n)           // [RULE2] [RULE3] [RULE5]
	begin
		if (cs_n)
		begin
			bit_cnt <= 5'h00;
			shift   <= 7'h00;
		end
		else
		begin
			if (bit_cnt != igoc_pkg::FRAME_BITS)
				bit_cnt <= bit_cnt + 5'h01;
			shift <= {shift[5:0], din};
		end
	end

	// Command byte latched on its eighth bit
	always_ff @(negedge sclk or posedge cs_n)
	begin
		if (cs_n)
			cmd <= 8'h00;
		else if (bit_cnt == igoc_pkg::CMD_LAST)
			cmd <= {shift, din};                          // [RULE5]
	end

	// Write handoff; toggle survives deselect so no event is lost
	always_ff @(negedge sclk or posedge link_rst)
	begin
		if (link_rst)
		begin
			lk.wr_tgl  <= 1'b0;
			lk.wr_addr <= 6'h00;
			lk.wr_data <= 8'h00;
		end
		else if (bit_cnt == igoc_pkg::DATA_LAST && cmd[igoc_pkg::CMD_WRITE_BIT])
		begin
			lk.wr_addr <= cmd[5:0];
			lk.wr_data <= {shift, din};
			lk.wr_tgl  <= ~lk.wr_tgl;
		end
	end

	// Read selection from the frozen snapshot
	always_comb
	begin
		if (cmd[5:0] == igoc_pkg::ADDR_GAIN_SEL)
			rd_byte = lk.snap_gain;
		else if (cmd[5:0] == igoc_pkg::ADDR_CH1_TRIM)
			rd_byte = lk.snap_ch1;
		else if (cmd[5:0] == igoc_pkg::ADDR_CH2_TRIM)
			rd_byte = lk.snap_ch2;
		else
			rd_byte = 8'h00;
	end

	// Output driven on the rising edge, enabled only in a read data phase
	always_ff @(posedge sclk or posedge cs_n)
	begin
		if (cs_n)
		begin
			lk.dout_oe <= 1'b0;                           // [RULE6]
			lk.dout    <= 1'b0;
		end
		else if (bit_cnt < igoc_pkg::CMD_BITS || bit_cnt == igoc_pkg::FRAME_BITS
			|| cmd[igoc_pkg::CMD_WRITE_BIT])
			lk.dout_oe <= 1'b0;                           // [RULE6]
		else
		begin
			lk.dout_oe <= 1'b1;
			lk.dout    <= rd_byte[~bit_cnt[2:0]];         // [RULE4]
		end
	end

	// ----------------------------------------------------------------
	// Link checks
	// ----------------------------------------------------------------
	a_write_quiet: assert property (@(posedge sclk) disable iff (cs_n) // [RULE6]
		cmd[igoc_pkg::CMD_WRITE_BIT] |=> !lk.dout_oe)
		else $error("data output enabled during a write frame");
	a_read_drives: assert property (@(posedge sclk) disable iff (cs_n) // [RULE4]
		!cmd[igoc_pkg::CMD_WRITE_BIT] && bit_cnt >= igoc_pkg::CMD_BITS
		&& bit_cnt < igoc_pkg::FRAME_BITS |=> lk.dout_oe)
		else $error("read data phase not driven");

endmodule : igoc_serial_link

// [igoc_host_model.sv]
// Purpose: Host end of the four-wire register port, driving frames
// Assumes: Serial clock idles high; 48 ns period inside frames only
// Notes:   Read bits are taken on falling edges from the resolved pin
`timescale 1ns/100ps
module igoc_host_model (
	input  wire logic dout,
	input  wire logic dout_oe,
	output logic      cs_n,
	output logic      sclk,
	output logic      din
);
	logic dout_last;
	logic dout_pin;

	// ------------------------------------------------------------
	// Pin level
	// ------------------------------------------------------------
	// A released pin shows the inverse of its last level, never a free match
	always @(dout or dout_oe)
		if (dout_oe === 1'b1)
			dout_last = dout;
	assign dout_pin = (dout_oe === 1'b1) ? dout : ~dout_last;

	// Idle levels: deselected, clock high
	// Select rises after time zero so the link clear sees a real edge
	initial
	begin
		sclk      = 1'b1;
		din       = 1'b0;
		dout_last = 1'b0;
		#1 cs_n   = 1'b1;
	end

	// ------------------------------------------------------------
	// Frames
	// ------------------------------------------------------------
	// Sel low gives noise the device must ignore; nbits below 16 aborts
	task automatic frame(input logic [7:0] cmd, input logic [7:0] wdat, input int nbits,
		input logic sel, output logic [7:0] rdat);
		logic [15:0] sh;
		sh   = {cmd, wdat};
		rdat = 8'h00;
		cs_n = ~sel;
		#16;
		for (int i = 0; i < nbits; i++)
		begin
			din = sh[15 - i];              // Held across the falling edge
			#24 sclk = 1'b0;
			if (i >= 8)
				rdat = {rdat[6:0], dout_pin};
			#24 sclk = 1'b1;
		end
		#24 cs_n = 1'b1;
		din = ~din;
		#40;                               // Gap above 8 system cycles
	endtask : frame
endmodule : igoc_host_model

// [tb_input_gain_offset_config.sv]
// Purpose: Self-checking bench for the gain and offset trim registers
// Assumes: Host model frames start 1 ns after a system clock edge
// Notes:   Expected values kept as shadow registers in the bench
`timescale 1ns/100ps
module tb_input_gain_offset_config;
	logic       clk_sys;
	logic       srst;
	logic       cs_n;
	logic       sclk;
	logic       din;
	logic       dout;
	logic       dout_oe;
	logic [2:0] ch1_gain_shift;
	logic [2:0] ch2_gain_shift;
	logic [1:0] ch1_range_sel;
	logic [5:0] ch1_offset;
	logic [5:0] ch2_offset;
	logic       ch1_integrator_en;
	logic       in_write;
	logic [7:0] exp_gain;
	logic [7:0] exp_ch1;
	logic [7:0] exp_ch2;
	logic [7:0] rd;
	logic [7:0] trims [3];
	int         failures;
	int         cmp_count;

	// System clock, 4 ns
	initial clk_sys = 1'b0;
	always #2 clk_sys = ~clk_sys;

	igoc_top i_dut (
		.clk_sys           (clk_sys),
		.srst              (srst),
		.cs_n              (cs_n),
		.sclk              (sclk),
		.din               (din),
		.dout              (dout),
		.dout_oe           (dout_oe),
		.ch1_gain_shift    (ch1_gain_shift),
		.ch2_gain_shift    (ch2_gain_shift),
		.ch1_range_sel     (ch1_range_sel),
		.ch1_offset        (ch1_offset),
		.ch2_offset        (ch2_offset),
		.ch1_integrator_en (ch1_integrator_en)
	);

	igoc_host_model i_host (
		.dout    (dout),
		.dout_oe (dout_oe),
		.cs_n    (cs_n),
		.sclk    (sclk),
		.din     (din)
	);

	// ------------------------------------------------------------
	// Compare tasks
	// ------------------------------------------------------------
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: read %h expected %h", $time, got, exp);
		end
	endtask : check8

	task automatic check_dec(input logic [20:0] exp);
		cmp_count++;
		if ({ch1_gain_shift, ch2_gain_shift, ch1_range_sel, ch1_offset, ch2_offset,
			ch1_integrator_en} !== exp)
		begin
			failures++;
			$display("mismatch at %0t: decoded outputs expected %h", $time, exp);
		end
	endtask : check_dec

	task automatic check_flag(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: port flag %b expected %b", $time, got, exp);
		end
	endtask : check_flag

	task automatic complete_run;
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// Expectations and bus tasks
	// ------------------------------------------------------------
	function automatic logic [2:0] sat(input logic [2:0] c);
		sat = (c > 3'h4) ? 3'h4 : c;
	endfunction : sat

	function automatic logic [5:0] trim(input logic [5:0] sm);
		trim = sm[5] ? 6'h00 - {1'b0, sm[4:0]} : {1'b0, sm[4:0]};
	endfunction : trim

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		in_write = 1'b1;
		i_host.frame({2'b10, a}, d, 16, 1'b1, rd);
		in_write = 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
		i_host.frame({2'b00, a}, 8'h00, 16, 1'b1, rd);
		check8(rd, exp);
	endtask : rd_chk

	// Decoded outputs then readback of all three registers
	task automatic check_all;
		check_dec({sat(exp_gain[2:0]), sat(exp_gain[7:5]), exp_gain[4:3], trim(exp_ch1[5:0]),
			trim(exp_ch2[5:0]), exp_ch1[7]});
		rd_chk(igoc_pkg::ADDR_GAIN_SEL, exp_gain);
		rd_chk(igoc_pkg::ADDR_CH1_TRIM, exp_ch1);
		rd_chk(igoc_pkg::ADDR_CH2_TRIM, exp_ch2);
	endtask : check_all

	// ------------------------------------------------------------
	// Pin monitors
	// ------------------------------------------------------------
	// Output enable low while deselected or during a write frame
	always @(posedge clk_sys)
		if (srst === 1'b0 && (cs_n === 1'b1 || in_write === 1'b1))
			check_flag(dout_oe, 1'b0);

	// Driven data may only move with a rising serial clock
	always @(dout)
		if (cs_n === 1'b0 && dout_oe === 1'b1)
			check_flag(sclk, 1'b1);

	// Hang guard, well beyond the full sequence
	initial
	begin
		#200000;
		failures++;
		complete_run();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		failures  = 0;
		cmp_count = 0;
		in_write  = 1'b0;
		#1 srst   = 1'b1;                  // Late rise, so the async link clear fires
		exp_gain  = 8'h00;
		exp_ch1   = 8'h80;
		exp_ch2   = 8'h00;
		trims     = '{8'h1f, 8'hff, 8'h20};
		repeat (20) @(posedge clk_sys);
		#1 srst = 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		check_all();
		// Every gain code on both channels, range codes in turn
		for (int c = 0; c < 8; c++)
		begin
			exp_gain = {3'h7 - 3'(c), 2'(c % 3), 3'(c)};
			wr(igoc_pkg::ADDR_GAIN_SEL, exp_gain);
			check_all();
		end
		// Sign and magnitude limits, minus zero, integrator bit
		for (int i = 0; i < 3; i++)
		begin
			wr(igoc_pkg::ADDR_CH1_TRIM, trims[i]);
			wr(igoc_pkg::ADDR_CH2_TRIM, trims[i] ^ 8'h20);
			exp_ch1 = trims[i] & 8'hbf;
			exp_ch2 = (trims[i] ^ 8'h20) & 8'h3f;
			check_all();
		end
		// Unmapped place: write ignored, reads as zero
		wr(6'h3e, 8'h55);
		rd_chk(6'h3e, 8'h00);
		// Deselected traffic and an aborted frame change nothing
		i_host.frame({2'b10, igoc_pkg::ADDR_GAIN_SEL}, 8'h00, 16, 1'b0, rd);
		in_write = 1'b1;
		i_host.frame({2'b10, igoc_pkg::ADDR_CH2_TRIM}, 8'h0a, 12, 1'b1, rd);
		in_write = 1'b0;
		check_all();
		complete_run();
	end
endmodule : tb_input_gain_offset_config
